// file: hw/bops_pkg.sv
// package: constants for the boot option parameter store
package bops_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    // register indices (parameter numbers)
    localparam logic [3:0]  IDX_PROGRESS    = 4'h0;
    localparam logic [3:0]  IDX_PART_CHOICE = 4'h1;
    localparam logic [3:0]  IDX_PART_SCAN   = 4'h2;
    localparam logic [3:0]  IDX_CLEAR_MASK  = 4'h3;
    localparam logic [3:0]  IDX_CONTROL     = 4'h4;
    localparam logic [3:0]  IDX_STATUS      = 4'h5;
    // set-in-progress codes
    localparam logic [1:0]  PROG_COMPLETE   = 2'h0;
    localparam logic [1:0]  PROG_ACTIVE     = 2'h1;
    localparam logic [1:0]  PROG_CODE_MASK  = 2'h3;
    // field masks of writable bits
    localparam logic [7:0]  SCAN_MASK       = 8'h03;
    localparam logic [7:0]  CLRMASK_MASK    = 8'h1F;
    // reset values
    localparam logic [7:0]  CHOICE_RST      = 8'h00;
    localparam logic [7:0]  SCAN_RST        = 8'h00;
    localparam logic [7:0]  CLRMASK_RST     = 8'h00;
    // mask bit positions
    localparam int          MB_WAKE         = 0;
    localparam int          MB_BUTTON       = 1;
    localparam int          MB_WATCHDOG     = 2;
    localparam int          MB_TIMEOUT      = 3;
    localparam int          MB_FILTER       = 4;
    localparam int          NUM_EVT         = 4;
    // control register bits
    localparam int          CTL_COMMIT      = 0;
    localparam int          CTL_SET_VALID   = 1;
    localparam int          CTL_ROLLBACK    = 2;
    // timeout
    localparam longint      CLK_HZ          = 40000000;
    localparam longint      TIMEOUT_S       = 60;
    localparam longint      TIMEOUT_CYC     = TIMEOUT_S * CLK_HZ;
    localparam int          TMR_W           = 32;
    localparam logic [31:0] TMR_ONE         = 32'h1;
    localparam logic [31:0] TMR_ZERO        = 32'h0;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
endpackage

// file: hw/bops_store.sv
// module: boot option parameter store with valid-bit clearing policy
`timescale 1ns/100ps
module bops_store
    import bops_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_LOAD = TIMEOUT_CYC[31:0],
    parameter bit          ROLLBACK_EN  = 1'b1
)
(
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    // register port
    input  wire logic [bops_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [bops_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [bops_pkg::DATA_W-1:0] reg_rdata,
    // system events, one-cycle pulses
    input  wire logic                        evt_sys_reset,
    input  wire logic                        evt_power_down,
    input  wire logic                        evt_filter_action,
    input  wire logic                        evt_watchdog,
    input  wire logic                        evt_button_reset,
    input  wire logic                        evt_power_up,
    input  wire logic                        chassis_cmd,
    // status
    output logic                             boot_valid,
    output logic                             set_in_progress
);
    import bops_pkg::*;

    // one-hot address decode
    function automatic logic hit_idx(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
        hit_idx = (a == idx);
    endfunction

    logic [1:0] prog_reg;
    logic [1:0] prog_next;
    logic [7:0] choice_reg;
    logic [7:0] choice_next;
    logic [7:0] scan_reg;
    logic [7:0] scan_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] choice_save_reg;
    logic [7:0] scan_save_reg;
    logic [7:0] mask_save_reg;
    logic       valid_reg;
    logic       valid_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic wr_prog;
    logic wr_choice;
    logic wr_scan;
    logic wr_mask;
    logic wr_ctl;
    logic enter_prog;
    logic drop_prog;
    logic abort_prog;
    logic do_commit;
    logic force_done;
    logic timed_out;
    logic tmr_arm;
    logic any_clear;
    logic [NUM_EVT-1:0] evt_vec;
    logic [NUM_EVT-1:0] evt_clear;

    // write decode; no gating on progress state
    assign wr_prog   = reg_wr && hit_idx(reg_addr, IDX_PROGRESS);
    assign wr_choice = reg_wr && hit_idx(reg_addr, IDX_PART_CHOICE);
    assign wr_scan   = reg_wr && hit_idx(reg_addr, IDX_PART_SCAN);
    assign wr_mask   = reg_wr && hit_idx(reg_addr, IDX_CLEAR_MASK);
    assign wr_ctl    = reg_wr && hit_idx(reg_addr, IDX_CONTROL);

    // progress state transitions
    assign force_done = evt_sys_reset || evt_power_down;
    assign enter_prog = wr_prog && (reg_wdata[1:0] == PROG_ACTIVE);
    assign drop_prog  = wr_prog && (reg_wdata[1:0] == PROG_COMPLETE);
    assign do_commit  = wr_ctl && reg_wdata[CTL_COMMIT];
    // leaving in-progress by a complete write or by forced completion, unless a commit lands in the same cycle
    assign abort_prog = ROLLBACK_EN && (prog_reg == PROG_ACTIVE)
                        && (drop_prog || force_done)
                        && !do_commit;

    // reserved codes are ignored, legal codes stored at once
    assign prog_next = force_done ? PROG_COMPLETE :
                       (enter_prog || drop_prog) ?
                       (reg_wdata[1:0] & PROG_CODE_MASK) : prog_reg;

    // parameter data; writes land unless a rollback in the same cycle restores the snapshot
    assign choice_next = abort_prog ? choice_save_reg :
                         wr_choice ? reg_wdata : choice_reg;
    assign scan_next   = abort_prog ? scan_save_reg :
                         wr_scan ? (reg_wdata & SCAN_MASK) : scan_reg;
    assign mask_next   = abort_prog ? mask_save_reg :
                         wr_mask ? (reg_wdata & CLRMASK_MASK) : mask_reg;

    // reset events in mask-bit order: wake, button, watchdog, filter
    assign evt_vec = {evt_filter_action, evt_watchdog, evt_button_reset, evt_power_up};

    // each event clears unless its mask bit protects the flag
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++)
        begin : g_evt
            localparam int MB = (gi == NUM_EVT - 1) ? MB_FILTER : gi;
            assign evt_clear[gi] = evt_vec[gi] && !mask_reg[MB];
        end
    endgenerate

    // chassis command timeout, armed only while flag set and unmasked
    assign tmr_arm   = valid_reg && !mask_reg[MB_TIMEOUT];
    assign any_clear = (|evt_clear) || (timed_out && !mask_reg[MB_TIMEOUT]);

    // software set wins over an event clear in the same cycle
    assign valid_next = (wr_ctl && reg_wdata[CTL_SET_VALID]) ? 1'b1 :
                        any_clear ? 1'b0 : valid_reg;

    bops_timeout #(
        .LOAD_CYC (TIMEOUT_LOAD)
    ) u_timeout (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .arm     (tmr_arm),
        .restart (chassis_cmd),
        .expired (timed_out)
    );

    // read data mux; reserved bits read as zero
    assign rdata_next = !reg_rd ? BYTE_ZERO :
        hit_idx(reg_addr, IDX_PROGRESS)    ? {6'h00, prog_reg} :
        hit_idx(reg_addr, IDX_PART_CHOICE) ? choice_reg :
        hit_idx(reg_addr, IDX_PART_SCAN)   ? scan_reg :
        hit_idx(reg_addr, IDX_CLEAR_MASK)  ? mask_reg :
        hit_idx(reg_addr, IDX_STATUS)      ? {7'h00, valid_reg} :
        BYTE_ZERO;

    assign reg_rdata       = rdata_reg;
    assign boot_valid      = valid_reg;
    assign set_in_progress = (prog_reg == PROG_ACTIVE);

    // progress state and read data
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prog_reg  <= PROG_COMPLETE;
            rdata_reg <= BYTE_ZERO;
        end
        else
        begin
            prog_reg  <= prog_next;
            rdata_reg <= rdata_next;
        end
    end

    // parameter data registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            choice_reg <= CHOICE_RST;
            scan_reg   <= SCAN_RST;
            mask_reg   <= CLRMASK_RST;
            valid_reg  <= 1'b0;
        end
        else
        begin
            choice_reg <= choice_next;
            scan_reg   <= scan_next;
            mask_reg   <= mask_next;
            valid_reg  <= valid_next;
        end
    end

    // snapshot on entering in-progress or on commit
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            choice_save_reg <= CHOICE_RST;
            scan_save_reg   <= SCAN_RST;
            mask_save_reg   <= CLRMASK_RST;
        end
        else if ((enter_prog && prog_reg != PROG_ACTIVE) || do_commit)
        begin
            choice_save_reg <= do_commit ? choice_next : choice_reg;
            scan_save_reg   <= do_commit ? scan_next : scan_reg;
            mask_save_reg   <= do_commit ? mask_next : mask_reg;
        end
    end
endmodule

// file: hw/bops_timeout.sv
// module: countdown for the chassis control timeout
`timescale 1ns/100ps
module bops_timeout
    import bops_pkg::*;
#(
    parameter logic [31:0] LOAD_CYC = TIMEOUT_CYC[31:0]
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // control
    input  wire logic arm,
    input  wire logic restart,
    // result
    output logic      expired
);
    logic [TMR_W-1:0] count_reg;
    logic [TMR_W-1:0] count_next;
    logic             expired_reg;
    logic             hit;

    // reload on restart, count while armed, stop at zero
    assign hit        = arm && !restart && (count_reg == TMR_ONE);
    assign count_next = (restart || !arm) ? LOAD_CYC :
                        (count_reg == TMR_ZERO) ? TMR_ZERO : count_reg - TMR_ONE;
    assign expired    = expired_reg;

    // counter and one-cycle expiry pulse
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_reg   <= TMR_ZERO;
            expired_reg <= 1'b0;
        end
        else
        begin
            count_reg   <= count_next;
            expired_reg <= hit;
        end
    end
endmodule

// file: sim/bops_fw_model.sv
// partner: host firmware model on the register port
`timescale 1ns/100ps
module bops_fw_model
    import bops_pkg::*;
(
    // clock and read data
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    // requests
    output logic      [3:0] reg_addr = 4'h0,
    output logic      [7:0] reg_wdata = 8'h00,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0
);
    // one-cycle write, address and data inverted after release
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        // data stands only until the next rising edge; take it mid-cycle
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // firmware pass over the scan parameter after a reset
    task automatic scan_pass(input logic found);
        logic [7:0] s;
        rd(IDX_PART_SCAN, s);
        if (s[1])
            wr(IDX_PART_SCAN, {7'h00, found});
        else
            wr(IDX_PART_SCAN, 8'h00);
    endtask
endmodule

// file: sim/bops_store_properties.sv
// checker: timing properties of the boot option parameter store
`timescale 1ns/100ps
module bops_store_properties
    import bops_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_LOAD = 32'h14
)
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // events and status
    input wire logic       evt_sys_reset,
    input wire logic       evt_power_down,
    input wire logic       evt_filter_action,
    input wire logic       evt_watchdog,
    input wire logic       evt_button_reset,
    input wire logic       evt_power_up,
    input wire logic       chassis_cmd,
    input wire logic       boot_valid,
    input wire logic       set_in_progress
);
    logic [4:0]  mask_reg;
    logic [31:0] quiet_reg;
    // decoded writes, events in mask bit order
    wire       prog_wr = reg_wr && reg_addr == IDX_PROGRESS;
    wire       ctl_wr  = reg_wr && reg_addr == IDX_CONTROL;
    wire       side_wr = prog_wr || ctl_wr || (reg_wr && reg_addr == IDX_CLEAR_MASK);
    wire       sys_evt = evt_sys_reset || evt_power_down;
    wire [4:0] evt_v   = {evt_filter_action, 1'b0, evt_watchdog, evt_button_reset, evt_power_up};
    wire [4:0] hit_v   = evt_v & ~mask_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // mask copy and cycles of valid without chassis command
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_reg  <= 5'h00;
            quiet_reg <= 32'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == IDX_CLEAR_MASK)
                mask_reg <= reg_wdata[4:0];
            quiet_reg <= (!boot_valid || chassis_cmd || mask_reg[3]) ? 32'h0 : quiet_reg + 32'h1;
        end
    end
    sequence s_enter_active;
        prog_wr && reg_wdata[1:0] == PROG_ACTIVE && !sys_evt;
    endsequence
    a_enter_active: assert property (s_enter_active |=> set_in_progress)
        else $error("progress write not applied");
    a_write_done: assert property (prog_wr && reg_wdata[1:0] == PROG_COMPLETE |=> !set_in_progress)
        else $error("complete write not applied");
    a_reserved_code: assert property (prog_wr && reg_wdata[1] && !sys_evt |=> $stable(set_in_progress))
        else $error("reserved progress code accepted");
    a_sys_complete: assert property (sys_evt && !prog_wr |=> !set_in_progress)
        else $error("progress kept over system reset");
    a_mask_read: assert property (reg_rd && reg_addr == IDX_CLEAR_MASK |=> reg_rdata == {3'h0, $past(mask_reg)})
        else $error("clear mask read wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_event_clear: assert property (boot_valid && hit_v != 5'h00 && !ctl_wr |=> !boot_valid)
        else $error("valid kept over unmasked event");
    a_valid_keep: assert property (boot_valid && hit_v == 5'h00 && !side_wr && !sys_evt
        && (mask_reg[3] || quiet_reg < TIMEOUT_LOAD - 32'h3) |=> boot_valid)
        else $error("valid lost without cause");
    a_timeout_bound: assert property (quiet_reg <= TIMEOUT_LOAD + 32'h4)
        else $error("valid outlived chassis timeout");
endmodule
bind bops_store bops_store_properties #(.TIMEOUT_LOAD(TIMEOUT_LOAD)) chk_u (.clk_sys, .arst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .evt_sys_reset, .evt_power_down,
    .evt_filter_action, .evt_watchdog, .evt_button_reset, .evt_power_up, .chassis_cmd,
    .boot_valid, .set_in_progress);

// file: sim/test_boot_option_parameter_store.sv
// bench: self-checking test of the boot option parameter store
`timescale 1ns/100ps
module test_boot_option_parameter_store;
    import bops_pkg::*;
    localparam logic [31:0] TL = 32'h14;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic [5:0] ev = 6'h00; // sysrst, pwrdn, filter, watchdog, button, power-up
    logic       chassis_cmd = 1'b0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       reg_wr, reg_rd, boot_valid, set_in_progress;
    int         n_mismatch = 0;
    int         total_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    bops_fw_model fw_u (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    bops_store #(.TIMEOUT_LOAD(TL)) dut_u (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .evt_sys_reset(ev[5]), .evt_power_down(ev[4]),
        .evt_filter_action(ev[3]), .evt_watchdog(ev[2]), .evt_button_reset(ev[1]),
        .evt_power_up(ev[0]), .chassis_cmd, .boot_valid, .set_in_progress);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        fw_u.rd(a, d);
        check(d, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_sys);
        ev[i] <= 1'b1;
        @(posedge clk_sys);
        ev[i] <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rchk(IDX_PART_CHOICE, 8'h00);
        rchk(IDX_CLEAR_MASK, 8'h00);
        rchk(4'hF, 8'h00);
        fw_u.wr(IDX_PROGRESS, 8'h01);
        @(negedge clk_sys);
        check({7'h00, set_in_progress}, 8'h01);
        fw_u.wr(IDX_PROGRESS, 8'h02);
        rchk(IDX_PROGRESS, 8'h01);
        fw_u.wr(IDX_PART_CHOICE, 8'hA5);
        rchk(IDX_PART_CHOICE, 8'hA5);
        pulse(5);
        rchk(IDX_PROGRESS, 8'h00);
        rchk(IDX_PART_CHOICE, 8'h00);
        fw_u.wr(IDX_PROGRESS, 8'h01);
        fw_u.wr(IDX_PART_CHOICE, 8'h3C);
        fw_u.wr(IDX_CONTROL, 8'h01);
        fw_u.wr(IDX_PROGRESS, 8'h00);
        rchk(IDX_PART_CHOICE, 8'h3C);
        fw_u.wr(IDX_PROGRESS, 8'h01);
        pulse(4);
        check({7'h00, set_in_progress}, 8'h00);
        rchk(IDX_PROGRESS, 8'h00);
        fw_u.wr(IDX_CLEAR_MASK, 8'hFF);
        rchk(IDX_CLEAR_MASK, 8'h1F);
        for (int i = 0; i < 4; i++)
        begin
            fw_u.wr(IDX_CONTROL, 8'h02);
            pulse(i);
            check({7'h00, boot_valid}, 8'h01);
        end
        fw_u.wr(IDX_CLEAR_MASK, 8'h08);
        for (int i = 0; i < 4; i++)
        begin
            fw_u.wr(IDX_CONTROL, 8'h02);
            pulse(i);
            check({7'h00, boot_valid}, 8'h00);
        end
        fw_u.wr(IDX_CONTROL, 8'h02);
        repeat (TL + 10) @(posedge clk_sys);
        rchk(IDX_STATUS, 8'h01);
        fw_u.wr(IDX_CLEAR_MASK, 8'h00);
        pulse(0);
        fw_u.wr(IDX_CONTROL, 8'h02);
        repeat (TL - 6) @(posedge clk_sys);
        chassis_cmd <= 1'b1;
        @(posedge clk_sys);
        chassis_cmd <= 1'b0;
        repeat (TL - 6) @(posedge clk_sys);
        @(negedge clk_sys);
        check({7'h00, boot_valid}, 8'h01);
        for (int i = 0; i < TL && boot_valid; i++)
            @(negedge clk_sys);
        check({7'h00, boot_valid}, 8'h00);
        fw_u.wr(IDX_PART_SCAN, 8'hFE);
        fw_u.scan_pass(1'b1);
        rchk(IDX_PART_SCAN, 8'h01);
        fw_u.scan_pass(1'b1);
        rchk(IDX_PART_SCAN, 8'h00);
        test_done();
    end
    // overall run limit
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end
endmodule
